// ### hdl/comparator_control_and_irq.sv
// comparator control registers, change detector and interrupt request logic
// assumes the analog comparator output is asynchronous and that the port
// latch and pin direction come from logic on clk_in
//
// Implementation choices: the register addresses and the plain strobed port.
`default_nettype none

// Functional notes
// R1 - comparator powered only while comparator_on is set
// R2 - input_channel_select routes one analog pin to the inverting input
// R3 - reference_select picks internal reference or pin for non-inverting input
// R4 - pin shows result only with output enable, pin output, comparator on
// R5 - output_pin_enable overrides port latch regardless of comparator_on
// R6 - internal result registered each instruction cycle, pin unlatched
// R7 - output_invert flips the sense of the comparison result
// R8 - first latch captures result on every control register read
// R9 - second latch samples result on every first clock phase
// R10 - mismatch is xor of latches, cleared by read or return
// R11 - control register write also reloads first latch, clears mismatch
// R12 - change detection independent of output_pin_enable
// R13 - flag set on mismatch rising edge, not on its level
// R14 - after resync, return to old level raises the flag again
// R15 - software clears flag by writing 0; writing 1 sets it
// R16 - request needs all three enables; flag sets regardless
// R17 - comparator result readable as status bit at any time
// R18 - flag wakes from sleep with comparator and peripheral enables
// R19 - reset returns timer link register and comparator to off
// R20 - software waits about 1 us, clears mismatch and flag first
// R21 - raw comparator output passes a two-stage synchroniser
module comparator_control_and_irq
    import comparator_control_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [DATA_W-1:0] rdata_out,
    input wire logic analog_cmp_raw_in,
    output analog_ctrl_s analog_ctrl_out,
    input wire logic pin_direction_in,
    input wire logic port_latch_in,
    output logic pin_data_out,
    output logic pin_oe_out,
    output logic irq_out,
    output logic wake_out
);

    // ========================================================================
    // state
    cmp_state_s st;
    cmp_state_s next_st;

    logic wr_ctrl;
    logic rd_ctrl;
    logic wr_flag;
    logic cur_result;
    logic mismatch;
    logic next_mismatch;

    // the same bit test serves every single-bit write field
    function automatic logic bit_of(input logic [DATA_W-1:0] v, input int b);
        bit_of = v[b];
    endfunction : bit_of

    // ========================================================================
    // decode and comparator view
    assign wr_ctrl = wr_in && (addr_in == OFS_CMP_CTRL);
    assign rd_ctrl = rd_in && (addr_in == OFS_CMP_CTRL);
    assign wr_flag = wr_in && (addr_in == OFS_PERIPH_FLAG);
    // polarity applied to synchronised output; dead comparator reads low
    assign cur_result = st.on && (st.sync_b ^ st.pol); // R1 R7 R21
    assign mismatch = st.held ^ st.sample; // R10 R12

    // ========================================================================
    // next state
    always_comb
    begin
        next_st = st;
        next_mismatch = 1'b0;
        // two flops before anything reads the raw level
        next_st.sync_a = analog_cmp_raw_in; // R21
        next_st.sync_b = st.sync_a; // R21
        // instruction cycle phase counter
        if (st.phase == LAST_PHASE)
        begin
            next_st.phase = FIRST_PHASE;
        end
        else
        begin
            next_st.phase = st.phase + 2'h1;
        end
        // second latch, registered once per instruction cycle
        if (st.phase == FIRST_PHASE)
        begin
            next_st.sample = cur_result; // R6 R9
        end
        // a read or a write of the control register resyncs the first latch
        if (rd_ctrl || wr_ctrl)
        begin
            next_st.held = st.sample; // R8 R11 R14
        end
        next_st.mis_q = mismatch;
        // register writes
        if (wr_ctrl)
        begin
            next_st.on = bit_of(wdata_in, CC_ON_BIT); // R1
            next_st.oe = bit_of(wdata_in, CC_OE_BIT);
            next_st.pol = bit_of(wdata_in, CC_POL_BIT); // R7
            next_st.ref_sel = bit_of(wdata_in, CC_REF_BIT); // R3
            next_st.chan = bit_of(wdata_in, CC_CHAN_BIT); // R2
        end
        else if (wr_in && (addr_in == OFS_TIMER_LINK))
        begin
            next_st.link = wdata_in & TL_WRITE_MASK;
        end
        else if (wr_in && (addr_in == OFS_IRQ_CTRL))
        begin
            next_st.global_irq_enable = bit_of(wdata_in, IC_GIE_BIT);
            next_st.peripheral_irq_enable = bit_of(wdata_in, IC_PERIPHERAL_IRQ_ENABLE_BIT);
        end
        else if (wr_in && (addr_in == OFS_PERIPH_EN))
        begin
            next_st.cie = bit_of(wdata_in, PE_CMP_BIT);
        end
        else if (wr_flag)
        begin
            next_st.flag = bit_of(wdata_in, PF_CMP_BIT); // R15
        end
        // edge, not level, sets the flag; a set beats a same-cycle clear
        if (mismatch && !st.mis_q)
        begin
            next_st.flag = 1'b1; // R13 R14 R16
        end
        // read data for the cycle after the strobe
        next_st.rdata = REG_RESET;
        if (rd_in)
        begin
            if (addr_in == OFS_CMP_CTRL)
            begin
                next_st.rdata[CC_ON_BIT] = st.on;
                next_st.rdata[CC_RESULT_BIT] = st.sample; // R17
                next_st.rdata[CC_OE_BIT] = st.oe;
                next_st.rdata[CC_POL_BIT] = st.pol;
                next_st.rdata[CC_REF_BIT] = st.ref_sel;
                next_st.rdata[CC_CHAN_BIT] = st.chan;
            end
            else if (addr_in == OFS_TIMER_LINK)
            begin
                next_st.rdata = st.link;
                next_st.rdata[TL_RESULT_BIT] = st.sample; // R17
            end
            else if (addr_in == OFS_IRQ_CTRL)
            begin
                next_st.rdata[IC_GIE_BIT] = st.global_irq_enable;
                next_st.rdata[IC_PERIPHERAL_IRQ_ENABLE_BIT] = st.peripheral_irq_enable;
            end
            else if (addr_in == OFS_PERIPH_EN)
            begin
                next_st.rdata[PE_CMP_BIT] = st.cie;
            end
            else if (addr_in == OFS_PERIPH_FLAG)
            begin
                next_st.rdata[PF_CMP_BIT] = st.flag;
            end
        end
        next_mismatch = next_st.held ^ next_st.sample;
    end

    // ========================================================================
    // state register; clock enable freezes everything
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st <= '0; // R19
        end
        else if (ce_in)
        begin
            st <= next_st;
        end
    end

    // ========================================================================
    // outputs
    assign rdata_out = st.rdata;
    // analog selects follow the register bits directly; one assignment
    // fills the whole struct so the output variable has a single driver
    assign analog_ctrl_out = analog_ctrl_s'{
        power: st.on, // R1
        channel: st.chan, // R2
        reference: st.ref_sel // R3
    };
    // pin is not latched per instruction cycle, so it tracks the synchroniser
    // and leads the status bit by up to one instruction cycle
    assign pin_data_out = st.oe ? cur_result : port_latch_in; // R4 R5 R6
    assign pin_oe_out = !pin_direction_in; // R4
    assign irq_out = st.flag && st.cie && st.peripheral_irq_enable && st.global_irq_enable; // R16
    // comparator keeps running in sleep; only the two enables gate wake
    assign wake_out = st.flag && st.cie && st.peripheral_irq_enable; // R18

    // ========================================================================
    // checks
    sequence s_ctrl_touch;
        ce_in && (rd_ctrl || wr_ctrl) && (st.phase != FIRST_PHASE);
    endsequence

    sequence s_mis_rise;
        ce_in && mismatch && !st.mis_q;
    endsequence

    // two running edges out of reset, so both synchroniser flops moved
    sequence s_run_twice;
        rst_n_in && ce_in ##1 ce_in;
    endsequence

    a_power_follow: assert property ( // R1
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && wr_ctrl && !bit_of(wdata_in, CC_ON_BIT)
        |=> !analog_ctrl_out.power && !cur_result)
        else $error("comparator still powered after off write");

    a_pin_gating: assert property ( // R4
        @(posedge clk_in) disable iff (!rst_n_in)
        st.oe && !st.on |-> !pin_data_out)
        else $error("pin shows result while comparator off");

    a_pin_override: assert property ( // R5
        @(posedge clk_in) disable iff (!rst_n_in)
        !st.oe |-> pin_data_out == port_latch_in)
        else $error("port latch not passed when override off");

    a_sample_phase: assert property ( // R9
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && st.phase != FIRST_PHASE |=> $stable(st.sample))
        else $error("second latch moved outside first phase");

    a_read_capture: assert property ( // R8
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && rd_ctrl |=> st.held == $past(st.sample))
        else $error("first latch missed read capture");

    a_touch_clears: assert property ( // R11
        @(posedge clk_in) disable iff (!rst_n_in)
        s_ctrl_touch |=> !mismatch)
        else $error("mismatch survived control access");

    a_flag_on_edge: assert property ( // R13
        @(posedge clk_in) disable iff (!rst_n_in)
        s_mis_rise |=> st.flag ##1 (st.flag || $past(wr_flag)))
        else $error("flag not set on mismatch edge");

    a_flag_level: assert property ( // R13
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && !st.flag && mismatch && st.mis_q && !wr_flag
        |=> !st.flag)
        else $error("flag set again by mismatch level");

    a_flag_write: assert property ( // R15
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && wr_flag && bit_of(wdata_in, PF_CMP_BIT) |=> st.flag)
        else $error("written one did not set flag");

    a_irq_enables: assert property ( // R16
        @(posedge clk_in) disable iff (!rst_n_in)
        irq_out |-> st.flag && st.global_irq_enable && st.peripheral_irq_enable && st.cie && wake_out)
        else $error("request without all enables");

    a_status_read: assert property ( // R17
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && rd_ctrl
        |=> rdata_out[CC_RESULT_BIT] == $past(st.sample))
        else $error("status bit wrong on read");

    a_mis_next: assert property ( // R10
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in |=> mismatch == $past(next_mismatch))
        else $error("mismatch not xor of latches");

    // mismatch stands while neither latch may move
    a_mis_hold: assert property ( // R10
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && mismatch && !rd_ctrl && !wr_ctrl
        && (st.phase != FIRST_PHASE) |=> mismatch)
        else $error("mismatch dropped without read or return");

    // flag life: software alone clears it, only an edge or a written one sets it
    a_flag_clear: assert property ( // R15
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && wr_flag && !bit_of(wdata_in, PF_CMP_BIT)
        && !(mismatch && !st.mis_q) |=> !st.flag)
        else $error("written zero did not clear flag");

    a_flag_hold: assert property ( // R15
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && st.flag && !wr_flag |=> st.flag)
        else $error("flag dropped without software clear");

    a_flag_no_edge: assert property ( // R13
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && !st.flag && !wr_flag
        && !(mismatch && !st.mis_q) |=> !st.flag)
        else $error("flag set without mismatch edge");

    // instruction cycle timing of the second latch
    a_phase_wrap: assert property ( // R6
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && (st.phase == LAST_PHASE) |=> st.phase == FIRST_PHASE)
        else $error("phase counter did not wrap");

    a_sample_load: assert property ( // R9
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && (st.phase == FIRST_PHASE) |=> st.sample == $past(cur_result))
        else $error("second latch missed first phase load");

    // raw level reaches the second flop two running edges later
    a_sync_delay: assert property ( // R21
        @(posedge clk_in) disable iff (!rst_n_in)
        s_run_twice |=> st.sync_b == $past(analog_cmp_raw_in, 2))
        else $error("synchroniser depth wrong");

    a_write_select: assert property ( // R2 R3
        @(posedge clk_in) disable iff (!rst_n_in)
        ce_in && wr_ctrl
        |=> analog_ctrl_out.channel == $past(wdata_in[CC_CHAN_BIT])
            && analog_ctrl_out.reference == $past(wdata_in[CC_REF_BIT]))
        else $error("analog selects not taken from control write");

    // pin tracks the synchroniser, not the instruction-cycle latch
    a_pin_follow: assert property ( // R4
        @(posedge clk_in) disable iff (!rst_n_in)
        st.oe && st.on |-> pin_data_out == (st.sync_b ^ st.pol))
        else $error("pin does not follow comparator");

    a_wake_gate: assert property ( // R18
        @(posedge clk_in) disable iff (!rst_n_in)
        st.flag && st.cie && st.peripheral_irq_enable |-> wake_out && (irq_out == st.global_irq_enable))
        else $error("wake or request gated wrongly");

    // no disable here: this one watches the reset itself
    a_reset_state: assert property ( // R19
        @(posedge clk_in)
        !rst_n_in
        |=> !analog_ctrl_out.power && !irq_out && rdata_out == REG_RESET)
        else $error("state not cleared by reset");

endmodule : comparator_control_and_irq

`default_nettype wire

// ### hdl/comparator_control_pkg.sv
// constants, register map and state layout for the comparator control block
// assumes a single clock domain with four clock periods per instruction cycle
`default_nettype none

package comparator_control_pkg;

    // ========================================================================
    // register bus shape and offsets
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_CMP_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_TIMER_LINK = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CTRL = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_PERIPH_EN = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_PERIPH_FLAG = 3'h4;

    // ========================================================================
    // field positions
    localparam int CC_ON_BIT = 7;
    localparam int CC_RESULT_BIT = 6;
    localparam int CC_OE_BIT = 5;
    localparam int CC_POL_BIT = 4;
    localparam int CC_REF_BIT = 2;
    localparam int CC_CHAN_BIT = 0;
    localparam int TL_RESULT_BIT = 0;
    localparam int IC_GIE_BIT = 7;
    localparam int IC_PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int PE_CMP_BIT = 3;
    localparam int PF_CMP_BIT = 3;

    // ========================================================================
    // reset values and timing
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [DATA_W-1:0] TL_WRITE_MASK = 8'hFE;
    localparam int PHASES = 4;
    localparam logic [1:0] FIRST_PHASE = 2'h0;
    localparam logic [1:0] LAST_PHASE = 2'(PHASES - 1);

    // ========================================================================
    // analog front end controls
    typedef struct packed {
        logic power;
        logic channel;
        logic reference;
    } analog_ctrl_s;

    // complete state of the block
    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic [1:0] phase;
        logic on;
        logic oe;
        logic pol;
        logic ref_sel;
        logic chan;
        logic [DATA_W-1:0] link;
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic cie;
        logic flag;
        logic held;
        logic sample;
        logic mis_q;
        logic [DATA_W-1:0] rdata;
    } cmp_state_s;

endpackage : comparator_control_pkg

`default_nettype wire

// ### sim/analog_front_model.sv
// far-side model: three pin voltages, an internal reference and the comparator
// assumes the block's analog controls are registered on its own clock
`default_nettype none

module analog_front_model
    import comparator_control_pkg::*;
#(
    parameter int REF_LEVEL = 55
)
(
    input wire analog_ctrl_s ctrl_in,
    input wire logic [7:0] pos_pin_in,
    input wire logic [7:0] neg_a_in,
    input wire logic [7:0] neg_b_in,
    output logic raw_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // input routing and comparison
    logic [7:0] pos;
    logic [7:0] neg;
    logic gt;

    // levels are unsigned steps; a tie counts as not greater
    assign pos = ctrl_in.reference ? 8'(REF_LEVEL) : pos_pin_in;
    assign neg = ctrl_in.channel ? neg_b_in : neg_a_in;
    assign gt = (pos > neg);
    // unpowered output is garbage, so show the opposite of the true answer
    assign raw_out = ctrl_in.power ? gt : !gt;
endmodule : analog_front_model

`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for the comparator control and interrupt block
// assumes one 125 MHz clock and the analog model on the far side
`default_nettype none

module testbench
    import comparator_control_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // signals
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic ce = 1'b1;
    logic dir = 1'b1;
    logic latch = 1'b1;
    logic [ADDR_W-1:0] addr = 3'h0;
    logic [DATA_W-1:0] wdata = 8'h00;
    logic [7:0] pos = 8'h32;
    logic [7:0] neg_a = 8'h28;
    logic [7:0] neg_b = 8'h3C;
    logic [DATA_W-1:0] rdata;
    analog_ctrl_s actl;
    logic raw, pdata, poe, irq, wake;
    int bad_count = 0;
    int num_checks = 0;

    comparator_control_and_irq comparator_control_and_irq_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata), .analog_cmp_raw_in(raw), .analog_ctrl_out(actl),
        .pin_direction_in(dir), .port_latch_in(latch),
        .pin_data_out(pdata), .pin_oe_out(poe), .irq_out(irq),
        .wake_out(wake));

    analog_front_model #(.REF_LEVEL(55)) analog_front_model_i (
        .ctrl_in(actl), .pos_pin_in(pos), .neg_a_in(neg_a),
        .neg_b_in(neg_b), .raw_out(raw));

    // ========================================================================
    // clock and helpers
    initial
    begin
        forever #4 clk_in = ~clk_in;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one-cycle strobes; a gap cycle follows so no signal is set twice
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    // move the input level, let it cross the synchroniser, then read flag
    task automatic step(input logic [7:0] v, input logic [7:0] exp);
        logic [7:0] x;
        @(posedge clk_in);
        pos <= v;
        repeat (10) @(posedge clk_in);
        rd(OFS_PERIPH_FLAG, x);
        check(x, exp);
    endtask : step

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    // ========================================================================
    // scenarios
    task automatic test_regs();
        logic [7:0] v;
        for (int a = 0; a < 8; a++)
        begin
            rd(3'(a), v);
            check(v, 8'h00);
        end
        wr(OFS_PERIPH_EN, 8'hFF);
        rd(OFS_PERIPH_EN, v);
        check(v, 8'h08);
        wr(OFS_TIMER_LINK, 8'hFF);
        rd(OFS_TIMER_LINK, v);
        check(v, 8'hFE);
        $display("test regs done");
    endtask : test_regs

    // every channel, reference and polarity combination
    task automatic test_select();
        logic [7:0] v;
        logic rf, ch, pl, res;
        for (int i = 0; i < 8; i++)
        begin
            {rf, ch, pl} = 3'(i);
            wr(OFS_CMP_CTRL, {2'b11, 1'b0, pl, 1'b0, rf, 1'b0, ch});
            repeat (10) @(posedge clk_in);
            res = ((rf ? 8'h37 : pos) > (ch ? neg_b : neg_a)) ^ pl;
            rd(OFS_CMP_CTRL, v);
            check(v, {1'b1, res, 1'b0, pl, 1'b0, rf, 1'b0, ch});
            check({5'h0, actl}, {5'h0, 1'b1, ch, rf});
        end
        $display("test select done");
    endtask : test_select

    // pin override by enable, direction and power
    task automatic test_pin();
        for (int j = 0; j < 8; j++)
        begin
            wr(OFS_CMP_CTRL, {j[1], 1'b0, j[2], 5'h00});
            dir <= j[0];
            repeat (10) @(posedge clk_in);
            check({6'h0, poe, pdata}, {6'h0, !j[0], j[2] ? j[1] : 1'b1});
        end
        $display("test pin done");
    endtask : test_pin

    task automatic test_irq();
        logic [7:0] v;
        // enable, let the bias settle about 1 us, resync, clear, then arm
        pos <= 8'h1E;
        wr(OFS_CMP_CTRL, 8'h80);
        repeat (125) @(posedge clk_in);
        rd(OFS_CMP_CTRL, v);
        wr(OFS_PERIPH_FLAG, 8'h00);
        wr(OFS_IRQ_CTRL, 8'hC0);
        wr(OFS_PERIPH_EN, 8'h08);
        step(8'h32, 8'h08);
        check({6'h0, irq, wake}, 8'h03);
        wr(OFS_PERIPH_FLAG, 8'h00);
        step(8'h32, 8'h00);
        step(8'h1E, 8'h00);
        step(8'h32, 8'h08);
        wr(OFS_PERIPH_FLAG, 8'h00);
        rd(OFS_CMP_CTRL, v);
        step(8'h1E, 8'h08);
        wr(OFS_PERIPH_FLAG, 8'h00);
        wr(OFS_CMP_CTRL, 8'h80);
        step(8'h32, 8'h08);
        // same change detection with the pin override on
        wr(OFS_PERIPH_FLAG, 8'h00);
        wr(OFS_CMP_CTRL, 8'hA0);
        step(8'h1E, 8'h08);
        wr(OFS_IRQ_CTRL, 8'h40);
        #1;
        check({6'h0, irq, wake}, 8'h01);
        wr(OFS_PERIPH_FLAG, 8'h00);
        #1;
        check({6'h0, irq, wake}, 8'h00);
        wr(OFS_PERIPH_FLAG, 8'h08);
        rd(OFS_PERIPH_FLAG, v);
        check(v, 8'h08);
        $display("test irq done");
    endtask : test_irq

    // a write with the clock enable low must not land
    task automatic test_freeze();
        logic [7:0] v;
        @(posedge clk_in);
        ce <= 1'b0;
        wr(OFS_PERIPH_EN, 8'h00);
        ce <= 1'b1;
        rd(OFS_PERIPH_EN, v);
        check(v, 8'h08);
        @(posedge clk_in);
        #1;
        check(rdata, 8'h00);
        $display("test freeze done");
    endtask : test_freeze

    // reset in mid-run with the comparator, link and flag all set
    task automatic test_reset();
        logic [7:0] v;
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        check({5'h0, actl}, 8'h00);
        check({6'h0, irq, wake}, 8'h00);
        rd(OFS_CMP_CTRL, v);
        check(v, 8'h00);
        rd(OFS_TIMER_LINK, v);
        check(v, 8'h00);
        rd(OFS_PERIPH_FLAG, v);
        check(v, 8'h00);
        $display("test reset done");
    endtask : test_reset

    // ========================================================================
    // main sequence and watchdog
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        test_regs();
        test_select();
        test_pin();
        test_irq();
        test_freeze();
        test_reset();
        finish_test();
    end

    initial
    begin
        #200000;
        bad_count++;
        finish_test();
    end
endmodule : testbench

`default_nettype wire
